// ===== design/dynamic_stream_put_unit.sv
// execution logic for the dynamic stream put instruction
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// What this block does
// - the source operand word is sent as the stream data word
// - link from low four bits of select register, link zero if out of range
// - four opcode bits decode sixteen variants
// - blocking variants stall the pipeline until the link has room
// - non-blocking never stalls; carry clear if room, set if none
// - tlast low for data variants, high for control variants
// - test-only acts normally but never asserts the link valid strobe
// - atomic variants keep interrupts off before the next instruction
// - privileged in user mode with mmu: cause 00111, no transfer
// - one cycle for area profile 0 or 2, two cycles for 1
// - a blocking stall still lets interrupts in unless atomic
// - instruction exists only with links above 0 and extended ops on
module dynamic_stream_put_unit
	import stream_put_pkg::*;
#(
	parameter int link_count_param = 16,
	parameter int mmu_enable_param = 0,
	parameter int privileged_stream_allow_param = 0,
	parameter int extended_stream_ops_param = 1,
	parameter int area_profile_param = 0
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic issue,
	input wire logic [stream_put_pkg::OP_W-1:0] variant,
	input wire logic [stream_put_pkg::DATA_W-1:0] source_operand_register,
	input wire logic [stream_put_pkg::DATA_W-1:0] link_select_register,
	input wire logic user_mode_flag,
	input wire logic irq_request,
	output logic busy,
	output logic done,
	output logic carry_we,
	output logic carry_val,
	output logic exc_raise,
	output logic [4:0] exception_cause_field,
	output logic irq_allow,
	output logic illegal_op,
	output logic [stream_put_pkg::MAX_LINKS-1:0] m_tvalid,
	output logic [stream_put_pkg::MAX_LINKS-1:0] m_tlast,
	output logic [stream_put_pkg::MAX_LINKS*stream_put_pkg::DATA_W-1:0] m_tdata,
	input wire logic [stream_put_pkg::MAX_LINKS-1:0] m_tready,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	import stream_put_pkg::*;

	// ==========================================================
	// configuration and decode
	localparam bit present = (link_count_param > 0)
		&& (extended_stream_ops_param == 1);
	localparam bit privileged = (mmu_enable_param >= 1)
		&& (privileged_stream_allow_param != 1);
	localparam int latency = (area_profile_param == 1) ? LAT_AREA
		: LAT_FAST;

	wire op_nb = variant[OP_NB_BIT];
	wire op_ctrl = variant[OP_CTRL_BIT];
	wire op_test = variant[OP_TEST_BIT];
	wire op_atom = variant[OP_ATOM_BIT];
	wire [SEL_W-1:0] raw_sel = link_select_register[SEL_W-1:0];
	wire [SEL_W-1:0] sel_link = (int'(raw_sel) >= link_count_param)
		? 4'h0 : raw_sel;
	wire start = clk_en & issue & ~busy & present;
	wire priv_fault = privileged & user_mode_flag;

	// ==========================================================
	// instruction latch
	put_state_t state;
	put_state_t next_state;
	logic nb;
	logic test;
	logic atom;
	logic ctrl;
	logic [SEL_W-1:0] link;
	logic [DATA_W-1:0] word;
	logic [1:0] cnt;
	logic atom_shadow;
	logic [2:0] status;
	logic [2:0] mask;

	link_if shared();
	logic [MAX_LINKS-1:0] ready_vec;
	wire sel_ready = |ready_vec;

	// ==========================================================
	// per-link ports
	genvar gi;
	generate
		for (gi = 0; gi < MAX_LINKS; gi++)
		begin : g_link
			stream_link_port #(.INDEX(4'(gi))) u_port (
				.shared(shared),
				.sel(link),
				.m_tvalid(m_tvalid[gi]),
				.m_tlast(m_tlast[gi]),
				.m_tdata(m_tdata[gi*DATA_W +: DATA_W]),
				.m_tready(m_tready[gi]),
				.ready_here(ready_vec[gi])
			);
		end
	endgenerate

	wire in_exec = (state == ST_EXEC) | (state == ST_WAIT);
	wire last_cycle = (cnt == 2'(latency - 1));
	// the word is offered only once the latency count has run out
	wire offer = in_exec & last_cycle;
	assign shared.tvalid = offer & ~test;
	assign shared.tdata = word;
	assign shared.tlast = ctrl;
	// the port modules only report readiness; the unit owns the bundle's copy
	assign shared.tready = sel_ready;
	wire finish = offer & (nb | shared.tready);

	// ==========================================================
	// control sequence
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (start & ~priv_fault)
					next_state = ST_EXEC;
			ST_EXEC, ST_WAIT:
				if (finish)
					next_state = ST_DONE;
				else if (last_cycle)
					next_state = ST_WAIT;
			// an issue in the done cycle is taken, else it would be lost
			ST_DONE:
				if (start & ~priv_fault)
					next_state = ST_EXEC;
				else
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			cnt <= 2'h0;
		end
		else if (clk_en)
		begin
			state <= next_state;
			if (state == ST_EXEC && !last_cycle)
				cnt <= cnt + 2'h1;
			else if (finish)
				cnt <= 2'h0; // keep the count through a wait
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			nb <= 1'b0;
			test <= 1'b0;
			atom <= 1'b0;
			ctrl <= 1'b0;
			link <= 4'h0;
			word <= DATA_RESET;
		end
		else if (start & ~priv_fault)
		begin
			nb <= op_nb;
			test <= op_test;
			atom <= op_atom;
			ctrl <= op_ctrl;
			link <= sel_link;
			word <= source_operand_register;
		end
	end

	// ==========================================================
	// results to the pipeline
	assign busy = (state != ST_IDLE) & (state != ST_DONE);
	assign done = finish & clk_en;
	assign carry_we = done & nb;
	assign carry_val = ~sel_ready;
	assign exc_raise = start & priv_fault;
	assign illegal_op = clk_en & issue & ~present;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			exception_cause_field <= EC_RESET;
		else if (exc_raise)
			exception_cause_field <= EC_PRIV_INSTR;
	end

	// atomic blocks interrupts during the put and up to the next one
	always_ff @(posedge core_clk)
	begin
		if (rst)
			atom_shadow <= 1'b0;
		else if (clk_en && done)
			atom_shadow <= atom;
		else if (clk_en && start)
			atom_shadow <= 1'b0;
	end
	// interrupts are taken during a blocking stall only when not atomic
	assign irq_allow = ~atom_shadow & ~(busy & atom);

	// ==========================================================
	// register bus and interrupt
	// sent means a real handshake, not a refused non-blocking offer
	wire ev_sent = done & shared.tvalid & sel_ready;
	wire ev_full = carry_we & ~sel_ready;
	wire [2:0] events = {exc_raise, ev_full, ev_sent};
	wire rd_status = reg_rd & (reg_addr == REG_STATUS);
	wire [31:0] next_rdata = (reg_addr == REG_STATUS) ? {29'h0, status}
		: (reg_addr == REG_MASK) ? {29'h0, mask}
		: (reg_addr == REG_INFO) ? {27'h0, atom_shadow, link}
		: 32'h00000000;

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			status <= IRQ_RESET;
			mask <= IRQ_RESET;
			reg_rdata <= 32'h00000000;
		end
		else if (clk_en)
		begin
			// a new event wins over the read clear
			status <= (rd_status ? 3'h0 : status) | events;
			if (reg_wr && reg_addr == REG_MASK)
				mask <= reg_wdata[2:0];
			reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
		end
	end
	assign irq = |(status & mask);

	// ==========================================================
	// checks
	// a refused non-blocking offer is withdrawn, so only blocking puts hold
	property p_hold;
		@(posedge core_clk) disable iff (rst)
		|m_tvalid && !(|(m_tvalid & m_tready)) && !nb && clk_en |=>
		$stable(m_tvalid) && $stable(m_tdata) && $stable(m_tlast);
	endproperty
	a_hold: assert property (p_hold)
		else $error("link output changed before accept");
	property p_ec;
		@(posedge core_clk) disable iff (rst)
		exc_raise |=> exception_cause_field == 5'h07 && !busy;
	endproperty
	a_ec: assert property (p_ec) else $error("wrong cause");
	property p_test;
		@(posedge core_clk) disable iff (rst)
		busy && test |-> m_tvalid == 16'h0000;
	endproperty
	a_test: assert property (p_test) else $error("test put wrote");
	property p_nb;
		@(posedge core_clk) disable iff (rst)
		issue && !busy && op_nb && clk_en && present && !priv_fault
		|-> ##[1:2] done;
	endproperty
	a_nb: assert property (p_nb) else $error("nonblocking stalled");
	property p_last;
		@(posedge core_clk) disable iff (rst)
		|m_tvalid |-> (m_tlast[link] == ctrl);
	endproperty
	a_last: assert property (p_last) else $error("bad tlast");
	property p_sel;
		@(posedge core_clk) disable iff (rst)
		shared.tvalid |-> m_tvalid == (16'h0001 << link);
	endproperty
	a_sel: assert property (p_sel) else $error("wrong link");
	property p_block;
		@(posedge core_clk) disable iff (rst)
		done && !nb |-> sel_ready;
	endproperty
	a_block: assert property (p_block) else $error("done w/o room");
	property p_atom;
		@(posedge core_clk) disable iff (rst)
		busy && atom |-> !irq_allow;
	endproperty
	a_atom: assert property (p_atom) else $error("irq in atomic");
	property p_lat;
		@(posedge core_clk) disable iff (rst)
		start && !priv_fault && op_nb && clk_en |->
		##(latency) done;
	endproperty
	a_lat: assert property (p_lat) else $error("latency wrong");
	c_block: cover property (@(posedge core_clk) state == ST_WAIT);
	c_exc: cover property (@(posedge core_clk) exc_raise);
	c_full: cover property (@(posedge core_clk) carry_we && carry_val);
	c_atom_wait: cover property (@(posedge core_clk)
		state == ST_WAIT && atom);
	c_ctrl: cover property (@(posedge core_clk)
		|(m_tvalid & m_tready & m_tlast));

	// ==========================================================
	// further checks

	// a faulting put must leave every link quiet
	property p_nopriv;
		@(posedge core_clk) disable iff (rst)
		exc_raise |=> m_tvalid == 16'h0000;
	endproperty
	a_nopriv: assert property (p_nopriv) else $error("fault sent");

	// carry reports the selected link's readiness
	property p_carry;
		@(posedge core_clk) disable iff (rst)
		carry_we |-> carry_val == !(|(m_tready & (16'h0001 << link)));
	endproperty
	a_carry: assert property (p_carry) else $error("bad carry");

	// a wait with no room on the link means the pipeline is held and nothing completes
	property p_wait;
		@(posedge core_clk) disable iff (rst)
		state == ST_WAIT && !sel_ready |-> busy && !done;
	endproperty
	a_wait: assert property (p_wait) else $error("wait let go");

	// the offered word is the latched source operand
	property p_tdata;
		@(posedge core_clk) disable iff (rst)
		|m_tvalid |-> m_tdata[link*DATA_W +: DATA_W] == word;
	endproperty
	a_tdata: assert property (p_tdata) else $error("bad data");

	// the cause field only moves on a fault
	property p_cause;
		@(posedge core_clk) disable iff (rst)
		!exc_raise |=> $stable(exception_cause_field);
	endproperty
	a_cause: assert property (p_cause) else $error("cause moved");
endmodule // dynamic_stream_put_unit

// ===== design/link_if.sv
// bundle of the one shared outgoing stream word between the unit and all sixteen port modules
`timescale 1ns/1ps
interface link_if;
	logic tvalid;
	logic tready;
	logic tlast;
	logic [31:0] tdata;
	modport src (output tvalid, output tlast, output tdata, input tready);
	modport dst (input tvalid, input tlast, input tdata, output tready);
endinterface

// ===== design/stream_link_port.sv
// per-link output stage: steers the shared word onto one stream master
`timescale 1ns/1ps
module stream_link_port
	import stream_put_pkg::*;
#(
	parameter logic [SEL_W-1:0] INDEX = 4'h0
)
(
	link_if.dst shared,
	input wire logic [SEL_W-1:0] sel,
	output logic m_tvalid,
	output logic m_tlast,
	output logic [DATA_W-1:0] m_tdata,
	input wire logic m_tready,
	output logic ready_here
);
	wire hit = (sel == INDEX);
	assign m_tvalid = hit & shared.tvalid;
	assign m_tlast = shared.tlast;
	assign m_tdata = shared.tdata;
	assign ready_here = hit & m_tready;
endmodule // stream_link_port

// ===== design/stream_put_pkg.sv
// shared constants and types for the dynamic stream put unit
package stream_put_pkg;
	localparam int DATA_W = 32;
	localparam int MAX_LINKS = 16;
	localparam int SEL_W = 4;
	localparam int OP_W = 4;
	// opcode bit positions within the variant field
	localparam int OP_NB_BIT = 3;
	localparam int OP_CTRL_BIT = 2;
	localparam int OP_TEST_BIT = 1;
	localparam int OP_ATOM_BIT = 0;
	localparam logic [4:0] EC_PRIV_INSTR = 5'h07;
	localparam logic [4:0] EC_RESET = 5'h00;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
	localparam int LAT_FAST = 1;
	localparam int LAT_AREA = 2;
	// register bus
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] REG_INFO = 4'h8;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam int EV_SENT = 0;
	localparam int EV_FULL = 1;
	localparam int EV_PRIV = 2;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_EXEC = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_DONE = 4'b1000
	} put_state_t;
endpackage

// ===== tb/stream_sink_model.sv
// receiving stream logic on all sixteen outgoing links
`timescale 1ns/1ps
module stream_sink_model
(
	input wire logic [15:0] hold,
	input wire logic [15:0] m_tvalid,
	output logic [15:0] m_tready
);
	// ready whenever room; the bench stalls a link through hold
	assign m_tready = ~hold;
endmodule // stream_sink_model

// ===== tb/tb_dynamic_stream_put_unit.sv
// self-checking bench for the dynamic stream put unit
`timescale 1ns/1ps
module tb_dynamic_stream_put_unit;
	import stream_put_pkg::*;
	localparam int LINKS = 12;
	logic core_clk, rst, issue, user, reg_wr, reg_rd, rd_d, illegal;
	logic nb_miss = 1'b0;
	logic [3:0] variant, reg_addr;
	logic [31:0] src, sel, reg_wdata, reg_rdata;
	logic busy, done, carry_we, carry_val, exc_raise, irq_allow, irq;
	logic [4:0] cause;
	logic [15:0] m_tvalid, m_tlast, m_tready, hold;
	logic [511:0] m_tdata;
	logic [36:0] xq[$];
	logic cq[$];
	logic [31:0] rq[$];
	int failures = 0;
	int n_compared = 0;
	// ==========================================
	// design, far side and clock
	dynamic_stream_put_unit #(.link_count_param(LINKS),
		.mmu_enable_param(1), .privileged_stream_allow_param(0))
	i_dynamic_stream_put_unit (.core_clk(core_clk), .rst(rst),
		.clk_en(1'b1), .issue(issue), .variant(variant),
		.source_operand_register(src), .link_select_register(sel),
		.user_mode_flag(user), .irq_request(1'b0), .busy(busy),
		.done(done), .carry_we(carry_we), .carry_val(carry_val),
		.exc_raise(exc_raise), .exception_cause_field(cause),
		.irq_allow(irq_allow), .illegal_op(illegal), .m_tvalid(m_tvalid),
		.m_tlast(m_tlast), .m_tdata(m_tdata), .m_tready(m_tready),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	stream_sink_model i_stream_sink_model (.hold(hold),
		.m_tvalid(m_tvalid), .m_tready(m_tready));
	initial
	begin
		core_clk = 0;
		forever #5 core_clk = ~core_clk;
	end
	// ==========================================
	// checking
	task automatic chk(input logic ok);
		n_compared++;
		if (ok !== 1'b1)
		begin
			failures++;
			$display("BAD %0t unexpected result", $time);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin : watch
		logic [36:0] e;
		rd_d <= reg_rd;
		if (!rst && |(m_tvalid & m_tready))
		begin
			e = (xq.size() > 0) ? xq.pop_front() : 37'h1FFFFFFFFF;
			chk(m_tready[e[36:33]] && m_tvalid[e[36:33]] === 1'b1 &&
				m_tlast[e[36:33]] === e[32] &&
				m_tdata[e[36:33]*DATA_W +: DATA_W] === e[31:0]);
		end
		else if (!rst && xq.size() == 0 && !nb_miss && m_tvalid !== 16'h0)
			chk(1'b0);
		if (!rst && illegal !== 1'b0)
			chk(1'b0);
		if (!rst && carry_we === 1'b1)
			chk(cq.size() > 0 && carry_val === cq.pop_front());
		if (rd_d)
			chk(rq.size() > 0 && reg_rdata === rq.pop_front());
	end
	// ==========================================
	// stimulus tasks
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] ex);
		rq.push_back(ex);
		@(posedge core_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
	endtask
	task automatic put(input logic [3:0] op, input logic [31:0] s,
		input logic um, input int stall);
		int cyc;
		logic [3:0] lk;
		logic seen, exc;
		logic [31:0] d;
		d = $urandom;
		cyc = 0;
		nb_miss = !um && op[OP_NB_BIT] && stall > 0;
		lk = (s[3:0] >= LINKS) ? 4'h0 : s[3:0];
		if (!um && !op[OP_TEST_BIT] && !(op[OP_NB_BIT] && stall > 0))
			xq.push_back({lk, op[OP_CTRL_BIT], d});
		if (!um && op[OP_NB_BIT])
			cq.push_back(stall > 0);
		@(posedge core_clk);
		hold <= (stall > 0) ? (16'h1 << lk) : 16'h0;
		issue <= 1;
		variant <= op;
		src <= d;
		sel <= s;
		user <= um;
		@(negedge core_clk);
		exc = exc_raise;
		seen = exc;
		@(posedge core_clk);
		issue <= 0;
		while (!seen && cyc < 60)
		begin
			@(negedge core_clk);
			cyc++;
			if (!um && busy && cyc < stall)
				chk(irq_allow === !op[OP_ATOM_BIT]);
			exc = exc | exc_raise;
			seen = exc | done;
			if (cyc == stall)
				@(posedge core_clk) hold <= 16'h0;
		end
		if (um)
			chk(exc);
		else if (stall == 0 || op[OP_NB_BIT])
			chk(cyc == LAT_FAST);
		else
			chk(seen && cyc > stall);
		@(negedge core_clk);
		if (um)
			chk(cause === EC_PRIV_INSTR);
		else
			chk(irq_allow === !op[OP_ATOM_BIT]);
		@(posedge core_clk) hold <= 16'h0;
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		{rst, issue, user, reg_wr, reg_rd, rd_d} = 6'b100000;
		{variant, reg_addr, src, sel, reg_wdata} = '0;
		hold = 16'h0;
		void'($urandom(31714));
		repeat (10) @(posedge core_clk);
		rst <= 0;
		rd(REG_MASK, 32'h00000000);
		wr(REG_MASK, 32'h00000007);
		put(4'h0, 32'h00000003, 0, 0);
		chk(irq === 1'b1);
		rd(REG_STATUS, 32'h00000001);
		@(negedge core_clk);
		chk(irq === 1'b0);
		rd(4'hC, 32'h00000000);
		wr(REG_MASK, 32'h00000000);
		put(4'h8, 32'h00000005, 0, 3);
		chk(irq === 1'b0);
		rd(REG_STATUS, 32'h00000002);
		for (int i = 0; i < 16; i++)
			put(i[3:0], $urandom, 0, 0);
		put(4'h4, 32'h0000000C, 0, 0);
		put(4'h0, 32'hFFFFFFFB, 0, 0);
		put(4'h0, 32'h00000005, 0, 6);
		put(4'h1, 32'h00000003, 0, 4);
		put(4'h0, 32'h00000002, 1, 0);
		repeat (3) @(posedge core_clk);
		chk(xq.size() == 0 && cq.size() == 0 && rq.size() == 0);
		give_verdict();
	end
	initial
	begin
		#100000;
		failures++;
		give_verdict();
	end
endmodule // tb_dynamic_stream_put_unit
